/* pkg/lsrs_defs.svh */
// Constants of the linear sensor readout sequencer.
// Assumes inclusion by bare name from any design file.
`ifndef LSRS_DEFS_SVH
`define LSRS_DEFS_SVH

// Pulse counts after the triggering edge (trigger edge is count 1)
`define LSRS_CNT_IDLE     9'h000
`define LSRS_CNT_FIRST    9'h001
`define LSRS_CNT_RST_LO   9'h002
`define LSRS_CNT_RST_HI   9'h003
`define LSRS_CNT_MAIN_OFF 9'h0FF
`define LSRS_CNT_LAST_OFF 9'h100
`define LSRS_CNT_TRACK    9'h101
`define LSRS_CNT_STEP     9'h001

// Pixel select values
`define LSRS_SEL_FIRST    8'h00

`endif

/* pkg/lsrs_pkg.sv */
// Types and helpers of the linear sensor readout sequencer.
// Assumes lsrs_defs.svh is on the include path.
`default_nettype none

package lsrs_pkg;

    // Sequencer states
    typedef enum logic [1:0] {
        LSRS_ST_POR  = 2'b00,
        LSRS_ST_IDLE = 2'b01,
        LSRS_ST_READ = 2'b10
    } lsrs_state_t;

    // State of the sequencer top
    typedef struct packed {
        logic [1:0]  si_s;
        logic [1:0]  rclk_s;
        logic        rclk_prev;
        logic [1:0]  shut_s;
        lsrs_state_t st;
        logic        hold_main;
        logic        hold_last;
        logic        integ_n;
        logic        integ_arm;
        logic        hold_dis;
        logic        photo_on;
    } lsrs_main_t;

    // State of the pixel index counter
    typedef struct packed {
        logic [8:0] cnt;
        logic [7:0] sel;
        logic       track;
    } lsrs_idx_t;

    // Compare a pulse count with a reference
    function automatic logic lsrs_cnt_is(input logic [8:0] cnt,
                                         input logic [8:0] ref_cnt);
        return cnt == ref_cnt;
    endfunction : lsrs_cnt_is

endpackage : lsrs_pkg

`default_nettype wire

/* pkg/lsrs_idx_if.sv */
// Link between the sequencer and its pixel index counter.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none

interface lsrs_idx_if;
    logic       start;
    logic       step;
    logic [8:0] cnt;
    logic [7:0] sel;
    logic       track;

    modport ctl (output start, output step,
                 input cnt, input sel, input track);
    modport idx (input start, input step,
                 output cnt, output sel, output track);
endinterface : lsrs_idx_if

`default_nettype wire

/* hdl/lsrs_idx.sv */
// Pixel index counter: counts readout pulses and selects the pixel.
// Assumes start and step are one-cycle enables on the sequencer clock.
`timescale 1ns/100ps
`default_nettype none
`include "lsrs_defs.svh"

module lsrs_idx (
    input  wire logic  clk,
    input  wire logic  rst_n,
    lsrs_idx_if.idx    ix
);

    lsrs_pkg::lsrs_idx_t q;
    lsrs_pkg::lsrs_idx_t d;
    logic [8:0]          nxt;

    // ========================================================
    // Next state
    // Start reloads pixel 1; each pulse after it advances, saturating in track
    always_comb begin
        d   = q;
        nxt = q.cnt;
        if (ix.start) begin
            nxt = `LSRS_CNT_FIRST;
        end else if (ix.step && q.cnt != `LSRS_CNT_IDLE &&
                     !lsrs_pkg::lsrs_cnt_is(q.cnt, `LSRS_CNT_TRACK)) begin
            nxt = q.cnt + `LSRS_CNT_STEP;
        end
        d.cnt   = nxt;
        d.track = lsrs_pkg::lsrs_cnt_is(nxt, `LSRS_CNT_TRACK);
        if (nxt == `LSRS_CNT_IDLE || d.track) begin
            d.sel = `LSRS_SEL_FIRST;
        end else begin
            d.sel = 8'((nxt - `LSRS_CNT_STEP));
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign ix.cnt   = q.cnt;
    assign ix.sel   = q.sel;
    assign ix.track = q.track;

endmodule : lsrs_idx

`default_nettype wire

/* hdl/lsrs_seq.sv */
// Linear sensor readout sequencer top: hold, integration reset, pixel mux.
// Assumes start, readout clock and shutter are asynchronous pins.
//
// Notes on behaviour
// - After reset discharge capacitors, pixels sample
// - Start high at readout clock rise triggers
// - Trigger edge sets main hold at once
// - Last pixel hold follows one pulse later
// - Integration reset low second to third fall
// - Output pixels in order from pixel 1
// - Release main hold, last hold one later
// - Early start restarts output at pixel 1
// - Past 256 pulses, pixel 1 tracks live
// - Shutter high disconnects photodiodes
// - Shutter low keeps integrating
`timescale 1ns/100ps
`default_nettype none
`include "lsrs_defs.svh"

module lsrs_seq (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       start_in,
    input  wire logic       readout_clk,
    input  wire logic       shutter_freeze,
    output logic            hold_select_main,
    output logic            hold_select_last,
    output logic            integ_reset_n,
    output logic            hold_discharge,
    output logic            photo_connect,
    output logic [7:0]      analog_pixel_sel,
    output logic            track_live,
    output logic            readout_busy
);

    // ========================================================
    // Reset release
    logic [1:0]             rst_s;
    logic                   rst_n;

    // Two-stage release of the asynchronous reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s <= 2'h0;
        end else begin
            rst_s <= {rst_s[0], 1'b1};
        end
    end
    assign rst_n = rst_s[1];

    // ========================================================
    // State and edges
    lsrs_pkg::lsrs_main_t   q;
    lsrs_pkg::lsrs_main_t   d;
    lsrs_idx_if             ix ();
    logic                   rise;
    logic                   fall;
    logic                   si;
    logic                   early;

    // Edges of the synchronised readout clock
    assign rise  = q.rclk_s[1] & ~q.rclk_prev;
    assign fall  = ~q.rclk_s[1] & q.rclk_prev;
    assign si    = q.si_s[1];
    assign early = ix.cnt < `LSRS_CNT_MAIN_OFF;

    // Index counter controls
    assign ix.start = rise & si;
    assign ix.step  = rise & ~si;

    lsrs_idx u_idx (
        .clk   (clk),
        .rst_n (rst_n),
        .ix    (ix)
    );

    // ========================================================
    // Sequencer next state
    always_comb begin
        d           = q;
        d.si_s      = {q.si_s[0], start_in};
        d.rclk_s    = {q.rclk_s[0], readout_clk};
        d.rclk_prev = q.rclk_s[1];
        d.shut_s    = {q.shut_s[0], shutter_freeze};
        d.photo_on  = ~q.shut_s[1];
        if (rise) begin
            case (q.st)
                lsrs_pkg::LSRS_ST_POR: begin
                    d.hold_dis = 1'b0;
                    d.integ_n  = 1'b1;
                    d.st       = lsrs_pkg::LSRS_ST_IDLE;
                end
                lsrs_pkg::LSRS_ST_IDLE: begin
                end
                lsrs_pkg::LSRS_ST_READ: begin
                    if (!si) begin
                        if (lsrs_pkg::lsrs_cnt_is(ix.cnt,
                                `LSRS_CNT_FIRST)) begin
                            d.hold_last = 1'b1;
                        end
                        if (lsrs_pkg::lsrs_cnt_is(ix.cnt,
                                `LSRS_CNT_MAIN_OFF)) begin
                            d.hold_main = 1'b0;
                        end
                        if (lsrs_pkg::lsrs_cnt_is(ix.cnt,
                                `LSRS_CNT_LAST_OFF)) begin
                            d.hold_last = 1'b0;
                            d.st        = lsrs_pkg::LSRS_ST_IDLE;
                        end
                    end
                end
                default: begin
                    d.st = lsrs_pkg::LSRS_ST_POR;
                end
            endcase
            // New readout; an early start only reloads the index
            if (si && !(q.st == lsrs_pkg::LSRS_ST_READ && early)) begin
                d.hold_main = 1'b1;
                d.hold_last = 1'b0;
                d.integ_arm = 1'b1;
                d.st        = lsrs_pkg::LSRS_ST_READ;
            end
        end
        // One-pulse integration reset on falls two and three
        if (fall && q.integ_arm && q.st == lsrs_pkg::LSRS_ST_READ) begin
            if (lsrs_pkg::lsrs_cnt_is(ix.cnt, `LSRS_CNT_RST_LO)) begin
                d.integ_n = 1'b0;
            end
            if (lsrs_pkg::lsrs_cnt_is(ix.cnt, `LSRS_CNT_RST_HI)) begin
                d.integ_n   = 1'b1;
                d.integ_arm = 1'b0;
            end
        end
    end

    // State register; reset discharges and puts pixels in sample mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q          <= '0;
            q.st       <= lsrs_pkg::LSRS_ST_POR;
            q.hold_dis <= 1'b1;
            q.photo_on <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Outputs
    assign hold_select_main = q.hold_main;
    assign hold_select_last = q.hold_last;
    assign integ_reset_n    = q.integ_n;
    assign hold_discharge   = q.hold_dis;
    assign photo_connect    = q.photo_on;
    assign analog_pixel_sel = ix.sel;
    assign track_live       = ix.track;
    assign readout_busy     = q.st == lsrs_pkg::LSRS_ST_READ;

    // ========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_por_clear: assert property (
        q.st == lsrs_pkg::LSRS_ST_POR |->
            hold_discharge && !integ_reset_n && !hold_select_main
    ) else $error("Power-on state not discharging");

    a_hold_trigger: assert property (
        rise && si && !readout_busy |=> hold_select_main && readout_busy
    ) else $error("Trigger did not set main hold");

    a_last_delay: assert property (
        $rose(hold_select_last) |->
            $past(rise) && hold_select_main &&
            $past(ix.cnt) == `LSRS_CNT_FIRST
    ) else $error("Last hold not one pulse after main");

    a_rst_fall: assert property (
        $fell(integ_reset_n) && readout_busy |->
            $past(fall) && ix.cnt == `LSRS_CNT_RST_LO
    ) else $error("Integration reset began at wrong edge");

    // Power-on exit raises the reset too, so that edge is left out
    a_rst_end: assert property (
        $rose(integ_reset_n) && readout_busy && !$past(hold_discharge) |->
            $past(fall) && ix.cnt == `LSRS_CNT_RST_HI
    ) else $error("Integration reset ended at wrong edge");

    a_idx_start: assert property (
        rise && si |=> analog_pixel_sel == `LSRS_SEL_FIRST &&
            ix.cnt == `LSRS_CNT_FIRST
    ) else $error("Start did not reload pixel 1");

    a_idx_step: assert property (
        rise && !si && readout_busy && ix.cnt < `LSRS_CNT_LAST_OFF |=>
            analog_pixel_sel == $past(analog_pixel_sel) + 8'h01
    ) else $error("Pixel index did not advance");

    a_main_release: assert property (
        $fell(hold_select_main) |->
            ix.cnt == `LSRS_CNT_LAST_OFF && hold_select_last
    ) else $error("Main hold released at wrong pulse");

    a_last_release: assert property (
        $fell(hold_select_last) && !hold_select_main |->
            ix.cnt == `LSRS_CNT_TRACK && track_live
    ) else $error("Last hold released at wrong pulse");

    a_restart_keep: assert property (
        rise && si && readout_busy && early |=>
            $stable(hold_select_main) && $stable(hold_select_last)
    ) else $error("Early restart changed hold state");

    a_track_live: assert property (
        track_live |-> analog_pixel_sel == `LSRS_SEL_FIRST && !hold_select_main
    ) else $error("Tracking without pixel 1 in sample");

    a_shutter_on: assert property (
        q.shut_s[1] |=> !photo_connect
    ) else $error("Shutter high left photodiodes connected");

    a_shutter_off: assert property (
        !q.shut_s[1] |=> photo_connect
    ) else $error("Shutter low stopped integration");

    c_readout: cover property ($fell(hold_select_main));
    c_restart: cover property (rise && si && readout_busy && early);
    c_track:   cover property ($rose(track_live));
    c_shutter: cover property ($fell(photo_connect) && readout_busy);

endmodule : lsrs_seq

`default_nettype wire

/* dv/lsrs_ctl_model.sv */
// Controller model: drives start, readout clock and shutter pins.
// Assumes the bench calls its tasks; pins idle low as with pull-downs.
`timescale 1ns/100ps
`default_nettype none

module lsrs_ctl_model (
    input  wire logic clk,
    output var  logic start_in,
    output var  logic readout_clk,
    output var  logic shutter_freeze
);
    // ==========================================================
    // Pin idle levels
    initial begin
        start_in       = 1'b0;
        readout_clk    = 1'b0;
        shutter_freeze = 1'b0;
    end

    // ==========================================================
    // Rising half: start set up 4 clk ahead and held past the edge
    task automatic rise(input logic st);
        @(posedge clk) start_in <= st;
        repeat (4) @(posedge clk);
        readout_clk <= 1'b1;
        repeat (7) @(posedge clk);
    endtask : rise

    // Falling half: start released with the clock, long low phase
    task automatic fall();
        @(posedge clk) readout_clk <= 1'b0;
        start_in <= 1'b0;
        repeat (7) @(posedge clk);
    endtask : fall

    // Shutter level, settled through the pin synchroniser
    task automatic shut(input logic v);
        @(posedge clk) shutter_freeze <= v;
        repeat (6) @(posedge clk);
    endtask : shut
endmodule : lsrs_ctl_model

`default_nettype wire

/* dv/lsrs_seq_tb.sv */
// Self-checking bench of the readout sequencer top.
// Assumes the controller model drives the three sensor pins.
`timescale 1ns/100ps
`default_nettype none

module lsrs_seq_tb;
    // ==========================================================
    // Signals
    logic        clk;
    logic        arst_n;
    logic        start_in;
    logic        readout_clk;
    logic        shutter_freeze;
    logic        hm;
    logic        hl;
    logic        ir_n;
    logic        hd;
    logic        pc;
    logic [7:0]  sel;
    logic        tr;
    logic        bz;
    logic [14:0] obs;
    int          bad_count;
    int          samples_checked;

    assign obs = {hm, hl, ir_n, hd, pc, sel, tr, bz};

    lsrs_ctl_model i_ctl (.clk(clk), .start_in(start_in),
        .readout_clk(readout_clk), .shutter_freeze(shutter_freeze));

    lsrs_seq i_dut (.clk(clk), .arst_n(arst_n), .start_in(start_in),
        .readout_clk(readout_clk), .shutter_freeze(shutter_freeze),
        .hold_select_main(hm), .hold_select_last(hl),
        .integ_reset_n(ir_n), .hold_discharge(hd), .photo_connect(pc),
        .analog_pixel_sel(sel), .track_live(tr), .readout_busy(bz));

    // ==========================================================
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end

    // ==========================================================
    // Expected outputs after pulse n; fl after its fall; rs restarted
    function automatic logic [14:0] expv(input int n, input bit fl,
                                         input bit rs);
        logic act;
        act = n >= 1 && n <= 256;
        return {1'(n >= 1 && n <= 255), 1'(act && (n >= 2 || rs)),
                1'(rs || !(n == 2 && fl || n == 3 && !fl)), 2'b01,
                act ? 8'(n - 1) : 8'h00, 1'(n >= 257), act};
    endfunction : expv

    task automatic chk(input logic [14:0] e);
        #1;
        samples_checked++;
        if (obs !== e) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, obs, e);
        end
    endtask : chk

    // One readout clock pulse with checks after rise and after fall
    task automatic step(input logic st, input int n, input bit rs);
        i_ctl.rise(st);
        chk(expv(n, 1'b0, rs));
        i_ctl.fall();
        chk(expv(n, 1'b1, rs));
    endtask : step

    // Pulses a..b, start high on the first one
    task automatic run(input int a, input int b, input bit rs);
        for (int n = a; n <= b; n++) begin
            step(n == a, (n > 257) ? 257 : n, rs);
        end
    endtask : run

    task automatic report_and_stop();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    // ==========================================================
    // Main sequence
    initial begin
        bad_count       = 0;
        samples_checked = 0;
        arst_n          = 1'b0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk(15'h0C00);
        step(1'b0, 0, 1'b0);
        run(1, 258, 1'b0);
        run(1, 10, 1'b0);
        run(1, 258, 1'b1);
        run(1, 2, 1'b0);
        i_ctl.shut(1'b1);
        chk(expv(2, 1'b1, 1'b0) ^ 15'h0400);
        i_ctl.shut(1'b0);
        chk(expv(2, 1'b1, 1'b0));
        @(posedge clk) arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk(15'h0C00);
        @(posedge clk) arst_n <= 1'b1;
        step(1'b1, 1, 1'b0);
        report_and_stop();
    end
endmodule : lsrs_seq_tb

`default_nettype wire
